// ==== rtl/tpc_pkg.sv ====
package tpc_pkg;

    // =========================================
    // sizes
    localparam int NCMD  = 4;
    localparam int NIN   = 4;
    localparam int NRLY  = 2;
    localparam int NALM  = 8;
    localparam int TS_W  = 32;
    localparam int CNT_W = 16;
    localparam int LOG_W = 48;
    localparam int LOG_AW = 12;

    // =========================================
    // timing
    localparam int CLK_HZ     = 125_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int MS_US      = 1000;
    localparam int MS_CYC     = MS_US * CYC_PER_US;
    localparam int QUAL_US    = 700;
    localparam int QUAL_CYC   = QUAL_US * CYC_PER_US;

    localparam logic [11:0] STEP_MS      = 12'h00a;
    localparam logic [7:0]  STEPS_MIN    = 8'h02;
    localparam logic [7:0]  STEPS_MAX    = 8'hfa;
    localparam logic [4:0]  DELAY_MIN_MS = 5'h01;
    localparam logic [4:0]  DELAY_MAX_MS = 5'h1e;
    localparam logic [5:0]  RELAY_MAX_S  = 6'h3c;
    localparam logic [15:0] MS_PER_S     = 16'h03e8;
    localparam logic [9:0]  SEC_LAST_MS  = 10'h3e7;
    localparam logic [9:0]  TEST_ONCE_MS = 10'h1f4;

    // =========================================
    // event log
    localparam logic [LOG_AW-1:0] LOG_DEPTH = 12'hbb8;
    localparam logic [LOG_AW-1:0] LOG_LAST  = 12'hbb7;
    localparam int LOG_TS_LSB = 16;
    localparam int LOG_TX_LSB = 12;
    localparam int LOG_RX_LSB = 8;
    localparam int LOG_AL_LSB = 0;

    // =========================================
    // alarm vector bit positions
    localparam int AL_RXBLK  = 0;
    localparam int AL_SIGLOS = 1;
    localparam int AL_LOWSNR = 2;
    localparam int AL_GUARD  = 3;
    localparam int AL_TSTFL  = 4;
    localparam int AL_DEVERR = 5;
    localparam int AL_MANBLK = 6;
    localparam int AL_CFGERR = 7;

    typedef enum logic [1:0] {
        DUR_FOLLOW,
        DUR_PROLONG,
        DUR_LIMIT,
        DUR_FIXED
    } tpc_dur_mode_t;

endpackage

// ==== rtl/tpc_event_mem.sv ====
`timescale 1ns/10ps
module tpc_event_mem import tpc_pkg::*; (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              reset,
    // write port
    input  wire logic              wrEn,
    input  wire logic [LOG_AW-1:0] wrAddr,
    input  wire logic [LOG_W-1:0]  wrData,
    // read port
    input  wire logic              rdEn,
    input  wire logic [LOG_AW-1:0] rdAddr,
    output logic      [LOG_W-1:0]  rdData
);

    logic [LOG_W-1:0] mem [int'(LOG_DEPTH)];

    // =========================================
    // storage
    always_ff @(posedge clock) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // =========================================
    // registered read
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdData <= '0;
        end else if (rdEn) begin
            rdData <= mem[rdAddr];
        end
    end

endmodule

// ==== rtl/tpc_command_io.sv ====
`timescale 1ns/10ps
// Contract
// - each command uses one to four inputs, any assigned one activates it
// - each input selects active on voltage present or voltage absent
// - extra transmit delay of 1 to 30 ms in 1 ms steps
// - transmit duration follow, prolonged, limited or fixed, 20..2500 ms
// - each received command drives one to four output contacts alike
// - output hold follow, prolonged, limited or fixed, 20..2500 ms
// - manual transmit test and loop-back, one-time or latched until cancel
// - local self-test starts repeatedly at the programmed period
// - counters of transmitted and received commands readable
// - counters of input and output activations readable
// - 3000-entry event log, oldest dropped when full, 1 ms timestamps
// - timestamp clock set from time code or network time source
// - front indicators for guard, loss, commands, blocking, test, loop
// - general alarm on any of eight alarm conditions
// - two relays, each independently signalling or alarm
// - signalling relay energizes on condition; alarm relay releases on alarm
// - relay changes after 0 to 60 s activation delay on condition onset, back at once when it ends
// - signalling relay driven by selected transmitted commands or outputs
// - alarm relay driven by selected combination of six alarms
module tpc_command_io import tpc_pkg::*; #(
    parameter int MS_CYCLES   = MS_CYC,
    parameter int QUAL_CYCLES = QUAL_CYC
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   reset,
    // command inputs and their setup
    input  wire logic [NCMD*NIN-1:0]    cmdInRaw,
    input  wire logic [NCMD*NIN-1:0]    inActiveLow,
    input  wire logic [NCMD*2-1:0]      inputsPerCmd,
    input  wire logic [NCMD*5-1:0]      txDelayMs,
    input  wire logic [NCMD*2-1:0]      txMode,
    input  wire logic [NCMD*8-1:0]      txSteps,
    // transmit side to modem
    output logic      [NCMD-1:0]        txCmd,
    // receive side and output contacts
    input  wire logic [NCMD-1:0]        rxCmd,
    input  wire logic [NCMD*2-1:0]      rxMode,
    input  wire logic [NCMD*8-1:0]      rxSteps,
    input  wire logic [NCMD*2-1:0]      outputsPerCmd,
    input  wire logic                   outputBlock,
    output logic      [NCMD*NIN-1:0]    cmdOut,
    // tests: bit 0 transmit test, bit 1 loop-back
    input  wire logic [1:0]             testStart,
    input  wire logic [1:0]             testPermanent,
    input  wire logic [1:0]             testStop,
    input  wire logic [15:0]            testPeriodS,
    output logic                        autoTestStart,
    input  wire logic                   autoTestDone,
    input  wire logic                   autoTestPass,
    // counters
    output logic      [CNT_W-1:0]       txCount,
    output logic      [CNT_W-1:0]       rxCount,
    output logic      [CNT_W-1:0]       inCount,
    output logic      [CNT_W-1:0]       outCount,
    // time sync
    input  wire logic                   syncSel,
    input  wire logic                   irigLoad,
    input  wire logic [TS_W-1:0]        irigTimeMs,
    input  wire logic                   sntpLoad,
    input  wire logic [TS_W-1:0]        sntpTimeMs,
    output logic      [TS_W-1:0]        timeMs,
    // event log read
    input  wire logic                   logPop,
    output logic      [LOG_W-1:0]       logData,
    output logic                        logValid,
    output logic      [LOG_AW-1:0]      logCount,
    // alarm conditions
    input  wire logic                   guardRx,
    input  wire logic                   rxBlocking,
    input  wire logic                   signalLoss,
    input  wire logic                   lowSnr,
    input  wire logic                   guardLevelErr,
    input  wire logic                   deviceError,
    input  wire logic                   manualBlock,
    input  wire logic                   configError,
    // front indicators
    output logic                        ledGuard,
    output logic                        ledSignalLoss,
    output logic      [NCMD-1:0]        ledTx,
    output logic      [NCMD-1:0]        ledRx,
    output logic                        ledOutBlock,
    output logic                        ledAutoTest,
    output logic                        ledLoop,
    output logic                        ledGeneralAlarm,
    // relays
    input  wire logic [NRLY-1:0]        relayAlarmMode,
    input  wire logic [NRLY*8-1:0]      relaySigSel,
    input  wire logic [NRLY*6-1:0]      relayAlarmSel,
    input  wire logic [NRLY*6-1:0]      relayDelayS,
    output logic      [NRLY-1:0]        relayEnergize
);

    localparam int PRE_W = $clog2(MS_CYCLES + 1);
    localparam int QW    = $clog2(QUAL_CYCLES + 1);

    function automatic logic [2:0] pop4(input logic [3:0] v);
        pop4 = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
    endfunction

    function automatic logic [3:0] thermo(input logic [1:0] n);
        logic [3:0] m;
        m = 4'h0;
        for (int j = 0; j < 4; j++) begin
            m[j] = (2'(j) <= n);
        end
        thermo = m;
    endfunction

    logic [PRE_W-1:0]    preCnt_ff;
    logic                msTick;
    logic [NCMD*NIN-1:0] inQual;
    logic [NCMD-1:0]     cmdQual;
    logic [NCMD-1:0]     txDelayed;
    logic [NCMD-1:0]     rxSrc;
    logic [7:0]          shOut;
    logic [1:0]          testActive;
    logic [NALM-1:0]     alarmVec;
    logic [NALM-1:0]     alarmPrev_ff;
    logic [NCMD-1:0]     txPrev_ff;
    logic [NCMD-1:0]     rxPrev_ff;
    logic [NCMD-1:0]     qualPrev_ff;
    logic [NCMD-1:0]     outPrev_ff;
    logic [NCMD-1:0]     outActive;
    logic                testFail_ff;
    logic [9:0]          secMs_ff;
    logic [15:0]         secCnt_ff;
    logic [LOG_AW-1:0]   wrPtr_ff;
    logic [LOG_AW-1:0]   rdPtr_ff;
    logic                logWr;
    logic                logTake;
    logic                logFull;
    logic [2*NCMD-1:0]   shIn;
    logic [2*NCMD*8-1:0] shSteps;
    logic [2*NCMD*2-1:0] shModes;

    // =========================================
    // millisecond tick and timestamp
    assign msTick = (preCnt_ff == PRE_W'(MS_CYCLES - 1));

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            preCnt_ff <= '0;
        end else begin
            preCnt_ff <= msTick ? '0 : preCnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            timeMs <= '0;
        end else if (syncSel ? sntpLoad : irigLoad) begin
            timeMs <= syncSel ? sntpTimeMs : irigTimeMs;
        end else if (msTick) begin
            timeMs <= timeMs + 1'b1;
        end
    end

    // =========================================
    // input qualification
    for (genvar k = 0; k < NCMD*NIN; k++) begin : g_in
        logic [QW-1:0] qCnt_ff;
        logic          level;
        assign level = cmdInRaw[k] ^ inActiveLow[k];
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                qCnt_ff <= '0;
            end else if (!level) begin
                qCnt_ff <= '0;
            end else if (qCnt_ff != QW'(QUAL_CYCLES)) begin
                qCnt_ff <= qCnt_ff + 1'b1;
            end
        end
        assign inQual[k] = (qCnt_ff == QW'(QUAL_CYCLES));
    end

    // =========================================
    // per command: input merge and transmit delay
    for (genvar c = 0; c < NCMD; c++) begin : g_cmd
        logic [4:0] dly;
        logic [4:0] dlyCnt_ff;
        assign cmdQual[c] = |(inQual[c*NIN +: NIN] & thermo(inputsPerCmd[c*2 +: 2]));
        assign dly = (txDelayMs[c*5 +: 5] < DELAY_MIN_MS) ? DELAY_MIN_MS :
                     (txDelayMs[c*5 +: 5] > DELAY_MAX_MS) ? DELAY_MAX_MS :
                     txDelayMs[c*5 +: 5];
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                dlyCnt_ff <= '0;
            end else if (!cmdQual[c]) begin
                dlyCnt_ff <= '0;
            end else if (msTick && dlyCnt_ff < dly) begin
                dlyCnt_ff <= dlyCnt_ff + 1'b1;
            end
        end
        assign txDelayed[c] = cmdQual[c] && (dlyCnt_ff >= dly);
        assign rxSrc[c] = testActive[1] ? txCmd[c] : rxCmd[c];
        assign outActive[c] = shOut[NCMD + c] && !outputBlock;
    end

    // =========================================
    // duration shaping: 0..3 transmit, 4..7 receive
    assign shIn    = {rxSrc, txDelayed};
    assign shSteps = {rxSteps, txSteps};
    assign shModes = {rxMode, txMode};
    for (genvar ch = 0; ch < 8; ch++) begin : g_shape
        logic          in;
        logic          rise;
        logic          prev_ff;
        logic          out_ff;
        logic [11:0]   tmr_ff;
        logic [7:0]    st;
        logic [11:0]   dur;
        tpc_dur_mode_t mode;
        assign in   = shIn[ch];
        assign st   = shSteps[ch*8 +: 8];
        assign mode = tpc_dur_mode_t'(shModes[ch*2 +: 2]);
        assign rise = in && !prev_ff;
        assign dur  = 12'((st < STEPS_MIN) ? STEPS_MIN :
                          (st > STEPS_MAX) ? STEPS_MAX : st) * STEP_MS;
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                prev_ff <= 1'b0;
                out_ff  <= 1'b0;
                tmr_ff  <= '0;
            end else begin
                prev_ff <= in;
                case (mode)
                    DUR_FOLLOW: begin
                        out_ff <= in;
                        tmr_ff <= '0;
                    end
                    DUR_PROLONG: begin
                        if (in) begin
                            tmr_ff <= dur;
                        end else if (msTick && tmr_ff != '0) begin
                            tmr_ff <= tmr_ff - 12'h001;
                        end
                        out_ff <= in || (tmr_ff != '0);
                    end
                    DUR_LIMIT: begin
                        if (rise) begin
                            tmr_ff <= dur;
                        end else if (msTick && tmr_ff != '0) begin
                            tmr_ff <= tmr_ff - 12'h001;
                        end
                        out_ff <= in && (rise || tmr_ff != '0);
                    end
                    DUR_FIXED: begin
                        if (rise && tmr_ff == '0) begin
                            tmr_ff <= dur;
                        end else if (msTick && tmr_ff != '0) begin
                            tmr_ff <= tmr_ff - 12'h001;
                        end
                        out_ff <= rise || (tmr_ff != '0);
                    end
                    default: begin
                        out_ff <= in;
                        tmr_ff <= '0;
                    end
                endcase
            end
        end
        assign shOut[ch] = out_ff;
    end

    // =========================================
    // transmit and contact outputs
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            txCmd  <= '0;
            cmdOut <= '0;
        end else begin
            txCmd <= shOut[NCMD-1:0] | {NCMD{testActive[0]}};
            for (int c = 0; c < NCMD; c++) begin
                cmdOut[c*NIN +: NIN] <= {NIN{outActive[c]}} &
                                        thermo(outputsPerCmd[c*2 +: 2]);
            end
        end
    end

    // =========================================
    // manual tests
    for (genvar t = 0; t < 2; t++) begin : g_test
        logic       latch_ff;
        logic [9:0] tmr_ff;
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                latch_ff <= 1'b0;
                tmr_ff   <= '0;
            end else if (testStop[t]) begin
                latch_ff <= 1'b0;
                tmr_ff   <= '0;
            end else if (testStart[t]) begin
                latch_ff <= testPermanent[t];
                tmr_ff   <= testPermanent[t] ? 10'h000 : TEST_ONCE_MS;
            end else if (msTick && tmr_ff != '0) begin
                tmr_ff <= tmr_ff - 10'h001;
            end
        end
        assign testActive[t] = latch_ff || (tmr_ff != '0);
    end

    // =========================================
    // periodic self-test
    // periodic start
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            secMs_ff      <= '0;
            secCnt_ff     <= '0;
            autoTestStart <= 1'b0;
        end else begin
            autoTestStart <= 1'b0;
            if (testPeriodS == '0) begin
                secMs_ff  <= '0;
                secCnt_ff <= '0;
            end else if (msTick) begin
                secMs_ff <= (secMs_ff == SEC_LAST_MS) ? 10'h000 : secMs_ff + 10'h001;
                if (secMs_ff == SEC_LAST_MS) begin
                    if (secCnt_ff + 16'h0001 >= testPeriodS) begin
                        secCnt_ff     <= '0;
                        autoTestStart <= 1'b1;
                    end else begin
                        secCnt_ff <= secCnt_ff + 16'h0001;
                    end
                end
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            testFail_ff <= 1'b0;
        end else if (autoTestDone) begin
            testFail_ff <= !autoTestPass;
        end
    end

    // =========================================
    // alarms and indicators
    always_comb begin
        alarmVec            = '0;
        alarmVec[AL_RXBLK]  = rxBlocking;
        alarmVec[AL_SIGLOS] = signalLoss;
        alarmVec[AL_LOWSNR] = lowSnr;
        alarmVec[AL_GUARD]  = guardLevelErr;
        alarmVec[AL_TSTFL]  = testFail_ff;
        alarmVec[AL_DEVERR] = deviceError;
        alarmVec[AL_MANBLK] = manualBlock;
        alarmVec[AL_CFGERR] = configError;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ledGuard        <= 1'b0;
            ledSignalLoss   <= 1'b0;
            ledTx           <= '0;
            ledRx           <= '0;
            ledOutBlock     <= 1'b0;
            ledAutoTest     <= 1'b0;
            ledLoop         <= 1'b0;
            ledGeneralAlarm <= 1'b0;
        end else begin
            ledGuard      <= guardRx;
            ledSignalLoss <= signalLoss;
            ledTx         <= txCmd;
            ledRx         <= shOut[2*NCMD-1:NCMD];
            ledOutBlock   <= outputBlock;
            ledAutoTest   <= testFail_ff;
            ledLoop       <= testActive[1];
            ledGeneralAlarm <= |alarmVec;
        end
    end

    // =========================================
    // activation counters
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            txPrev_ff    <= '0;
            rxPrev_ff    <= '0;
            qualPrev_ff  <= '0;
            outPrev_ff   <= '0;
            alarmPrev_ff <= '0;
            txCount      <= '0;
            rxCount      <= '0;
            inCount      <= '0;
            outCount     <= '0;
        end else begin
            txPrev_ff    <= txCmd;
            rxPrev_ff    <= shOut[2*NCMD-1:NCMD];
            qualPrev_ff  <= cmdQual;
            outPrev_ff   <= outActive;
            alarmPrev_ff <= alarmVec;
            txCount <= txCount + CNT_W'(pop4(txCmd & ~txPrev_ff));
            rxCount <= rxCount + CNT_W'(pop4(shOut[2*NCMD-1:NCMD] & ~rxPrev_ff));
            inCount  <= inCount + CNT_W'(pop4(cmdQual & ~qualPrev_ff));
            outCount <= outCount + CNT_W'(pop4(outActive & ~outPrev_ff));
        end
    end

    // =========================================
    // event log
    assign logFull = (logCount == LOG_DEPTH);
    assign logTake = logPop && (logCount != '0);
    assign logWr   = |(txCmd & ~txPrev_ff) || |(shOut[2*NCMD-1:NCMD] & ~rxPrev_ff) ||
                     (alarmVec != alarmPrev_ff);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            logCount <= '0;
            logValid <= 1'b0;
        end else begin
            logValid <= logTake;
            if (logWr) begin
                wrPtr_ff <= (wrPtr_ff == LOG_LAST) ? '0 : wrPtr_ff + 1'b1;
            end
            if (logTake || (logWr && logFull)) begin
                rdPtr_ff <= (rdPtr_ff == LOG_LAST) ? '0 : rdPtr_ff + 1'b1;
            end
            if (logWr && !logFull && !logTake) begin
                logCount <= logCount + 1'b1;
            end else if (logTake && !logWr) begin
                logCount <= logCount - 1'b1;
            end
        end
    end

    tpc_event_mem u_mem (
        .clock  (clock),
        .reset  (reset),
        .wrEn   (logWr),
        .wrAddr (wrPtr_ff),
        .wrData ({timeMs, txCmd & ~txPrev_ff,
                  shOut[2*NCMD-1:NCMD] & ~rxPrev_ff, alarmVec}),
        .rdEn   (logTake),
        .rdAddr (rdPtr_ff),
        .rdData (logData)
    );

    // =========================================
    // alarm and signalling relays
    for (genvar r = 0; r < NRLY; r++) begin : g_rly
        logic        cond;
        logic [15:0] target;
        logic [15:0] dCnt_ff;
        logic [5:0]  ds;
        assign cond = relayAlarmMode[r] ?
                      |(alarmVec[AL_DEVERR:AL_RXBLK] & relayAlarmSel[r*6 +: 6]) :
                      |({outActive, txCmd} & relaySigSel[r*8 +: 8]);
        assign ds = (relayDelayS[r*6 +: 6] > RELAY_MAX_S) ? RELAY_MAX_S :
                    relayDelayS[r*6 +: 6];
        assign target = 16'(ds) * MS_PER_S;
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                dCnt_ff <= '0;
            end else if (!cond) begin
                dCnt_ff <= '0;
            end else if (msTick && dCnt_ff < target) begin
                dCnt_ff <= dCnt_ff + 16'h0001;
            end
        end
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                relayEnergize[r] <= 1'b0;
            end else begin
                relayEnergize[r] <= relayAlarmMode[r] ^ (cond && dCnt_ff >= target);
            end
        end
    end

endmodule

// ==== verification/tpc_cio_sva.sv ====
`timescale 1ns/10ps
module tpc_cio_sva import tpc_pkg::*; (
    // watched ports
    input logic        clock,
    input logic        reset,
    input logic [3:0]  txCmd,
    input logic [15:0] txCount,
    input logic [3:0]  ledTx,
    input logic        signalLoss,
    input logic        ledGeneralAlarm,
    input logic        logPop,
    input logic        logValid,
    input logic [11:0] logCount,
    input logic        outputBlock,
    input logic [15:0] cmdOut,
    input logic        autoTestStart,
    input logic [1:0]  relayAlarmMode,
    input logic [15:0] relaySigSel,
    input logic [11:0] relayAlarmSel,
    input logic [11:0] relayDelayS,
    input logic [1:0]  relayEnergize
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    gen_alarm_a: assert property (signalLoss |=> ledGeneralAlarm)
        else $error("general alarm missing");
    tx_led_a: assert property ($rose(txCmd[0]) |=> ledTx[0])
        else $error("transmit indicator missing");
    tx_count_a: assert property ($rose(|txCmd) |=> txCount != $past(txCount, 2))
        else $error("transmit count stuck");
    log_bound_a: assert property (logCount <= LOG_DEPTH)
        else $error("log count too high");
    pop_valid_a: assert property (logPop && logCount != 12'h000 |=> logValid)
        else $error("log read missing");
    block_out_a: assert property (outputBlock [*2] |-> cmdOut == 16'h0000)
        else $error("blocked contact active");
    self_pulse_a: assert property (autoTestStart |=> !autoTestStart)
        else $error("self test start too long");
    relay_sig_a: assert property ((!relayAlarmMode[0] && relayDelayS[5:0] == 6'h00
        && relaySigSel[0] && txCmd[0]) [*2] |-> relayEnergize[0]) else $error("relay not set");
    relay_alarm_a: assert property ((relayAlarmMode[1] && relayDelayS[11:6] == 6'h00
        && relayAlarmSel[7] && signalLoss) [*2] |-> !relayEnergize[1]) else $error("relay held");
    cover property ($rose(txCmd[0]));
    cover property (logValid);
    cover property ($fell(relayEnergize[1]));
endmodule
bind tpc_command_io tpc_cio_sva chk (.*);

// ==== verification/tpc_prot_model.sv ====
`timescale 1ns/10ps
module tpc_prot_model (
    // trip side
    input logic         clock,
    input logic         trip,
    input logic         low,
    output logic [15:0] cmdInRaw,
    // contact side
    input logic [15:0]  cmdOut,
    output int          nSeen
);
    logic seen = 1'h0;
    int   cnt  = 0;
    assign cmdInRaw = 16'(trip ^ low) << 3;
    assign nSeen    = cnt;
    always @(posedge clock) begin
        seen <= |cmdOut;
        cnt  <= cnt + int'(|cmdOut && !seen);
    end
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    logic clock = 1'h0, reset = 1'h1, trip = 1'h0, outputBlock = 1'h0, syncSel = 1'h0;
    logic irigLoad = 1'h0, sntpLoad = 1'h0, logPop = 1'h0, autoTestDone = 1'h0;
    logic autoTestPass = 1'h0, guardRx = 1'h0, rxBlocking = 1'h0, signalLoss = 1'h0;
    logic lowSnr = 1'h0, guardLevelErr = 1'h0, deviceError = 1'h0, manualBlock = 1'h0;
    logic configError = 1'h0, logValid, autoTestStart, ledGuard, ledSignalLoss;
    logic ledOutBlock, ledAutoTest, ledLoop, ledGeneralAlarm;
    logic [1:0] testStart = 2'h0, testPermanent = 2'h0, testStop = 2'h0;
    logic [1:0] relayAlarmMode = 2'h2, relayEnergize;
    logic [3:0] rxCmd = 4'h0, txCmd, ledTx, ledRx;
    logic [7:0] inputsPerCmd = 8'h03, txMode = 8'h00, rxMode = 8'h00, outputsPerCmd = 8'h0c;
    logic [11:0] relayAlarmSel = 12'h080, relayDelayS = 12'h000, logCount;
    logic [15:0] cmdInRaw, inActiveLow = 16'h0008, cmdOut, testPeriodS = 16'h0000;
    logic [15:0] relaySigSel = 16'h0001, txCount, rxCount, inCount, outCount;
    logic [19:0] txDelayMs = 20'h00001;
    logic [31:0] txSteps = 32'h0, rxSteps = 32'h0, irigTimeMs = 32'h0, sntpTimeMs = 32'h0;
    logic [31:0] timeMs;
    logic [47:0] logData;
    int nErrors = 0, checksDone = 0, nSeen, i;
    tpc_command_io #(.MS_CYCLES(10), .QUAL_CYCLES(8)) uut (.*);
    tpc_prot_model prot (.clock, .trip, .low(inActiveLow[3]), .cmdInRaw, .cmdOut, .nSeen);
    always #4 clock = ~clock;
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checksDone++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            nErrors++;
        end
    endtask
    task summarize;
        if (nErrors == 0 && checksDone > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    initial begin
        tick(3);
        reset = 1'h0;
        tick(2);
        chk(relayEnergize, 2'h2);
        trip = 1'h1;
        tick(7);
        trip = 1'h0;
        tick(30);
        chk({txCmd, inCount}, 20'h00000);
        trip = 1'h1;
        for (i = 0; i < 60 && txCmd[0] !== 1'h1; i++) tick(1);
        chk(i > 8 && i < 23, 1'h1);
        if (i == 60) summarize();
        tick(3);
        chk({ledTx, txCount, inCount}, 36'h100010001);
        chk(relayEnergize, 2'h3);
        trip = 1'h0;
        tick(25);
        chk({txCmd, relayEnergize}, 6'h02);
        rxCmd = 4'h2;
        tick(4);
        chk({cmdOut, rxCount, outCount, ledRx}, 52'h00f0000100012);
        chk(nSeen, 48'h1);
        outputBlock = 1'h1;
        tick(3);
        chk({cmdOut, ledOutBlock}, 17'h00001);
        outputBlock = 1'h0;
        rxCmd = 4'h0;
        signalLoss = 1'h1;
        guardRx = 1'h1;
        tick(3);
        chk({ledGuard, ledSignalLoss, ledGeneralAlarm, relayEnergize}, 5'h1c);
        irigTimeMs = 32'h00012345;
        irigLoad = 1'h1;
        tick(1);
        irigLoad = 1'h0;
        chk(timeMs, 32'h00012345);
        logPop = 1'h1;
        tick(1);
        logPop = 1'h0;
        for (i = 0; i < 3 && logValid !== 1'h1; i++) tick(1);
        chk({logValid, logCount, logData[15:0]}, 29'h10021000);
        testPeriodS = 16'h0001;
        for (i = 0; i < 11000 && autoTestStart !== 1'h1; i++) tick(1);
        chk(i < 11000, 1'h1);
        autoTestDone = 1'h1;
        tick(1);
        autoTestDone = 1'h0;
        tick(2);
        chk(ledAutoTest, 1'h1);
        txMode = 8'h01;
        rxMode = 8'h03;
        txSteps = 32'h02;
        rxSteps = 32'h02;
        trip = 1'h1;
        rxCmd = 4'h1;
        tick(1);
        rxCmd = 4'h0;
        tick(40);
        trip = 1'h0;
        tick(60);
        chk({txCmd, cmdOut}, 20'h10001);
        tick(250);
        chk({txCmd, cmdOut}, 20'h00000);
        testPermanent = 2'h2;
        testStart = 2'h3;
        tick(1);
        testStart = 2'h0;
        tick(3);
        chk({txCmd, ledLoop, cmdOut}, 21'h1f11f1);
        testStop = 2'h3;
        tick(1);
        testStop = 2'h0;
        tick(4);
        chk({txCmd, ledLoop, cmdOut[15:4]}, 17'h00000);
        signalLoss = 1'h0;
        relayDelayS = 12'h040;
        tick(2);
        signalLoss = 1'h1;
        for (i = 0; i < 10100 && relayEnergize[1] !== 1'h0; i++) tick(1);
        chk(i > 9980 && i < 10020, 1'h1);
        summarize();
    end
endmodule
